// >>> rtl/clkgen_ctl_pkg.sv
// Constants for the clock generator control byte bank and its serial slave.
// Assumes a single 200 MHz system clock; serial lines arrive synchronous to it.
package clkgen_ctl_pkg;

  // ==========================================================
  // Serial addressing
  localparam logic [7:0] WR_ADDR_BYTE = 8'hD2;
  localparam logic [7:0] RD_ADDR_BYTE = 8'hD3;

  // ==========================================================
  // Register indices
  localparam logic [7:0] IDX_SYNTH_DIV = 8'h00;
  localparam logic [7:0] IDX_SPREAD = 8'h01;
  localparam logic [7:0] IDX_OUT_EN = 8'h02;
  localparam logic [7:0] NUM_BYTES = 8'h03;

  // ==========================================================
  // Byte 0 fields
  localparam int B0_MAIN_SYNTH = 7;
  localparam int B0_DOT_SYNTH = 6;
  localparam int B0_DISP_SYNTH = 5;
  localparam int B0_PROC_DIV = 3;
  localparam int B0_SERREF_DIV = 2;
  localparam int B0_DISP_DIV = 1;
  localparam int B0_DOT_DIV = 0;
  localparam logic [7:0] B0_WRITABLE = 8'hEF;
  localparam logic [7:0] B0_RESET = 8'hEF;

  // ==========================================================
  // Byte 1 fields
  localparam int B1_MAIN_SPREAD = 7;
  localparam int B1_DISP_SPREAD = 6;
  localparam int B1_SEL_LSB = 3;
  localparam logic [7:0] B1_WRITABLE = 8'hF8;
  localparam logic [7:0] B1_RESET = 8'hC0;

  // ==========================================================
  // Byte 2 fields: bit 7..5 proc a..c, 4..2 serref a..c, 1 dot, 0 display
  localparam logic [7:0] B2_WRITABLE = 8'hFF;
  localparam logic [7:0] B2_RESET = 8'hFF;

  // ==========================================================
  // Display spread select codes
  localparam logic [2:0] SPR_DOWN_0P5 = 3'h0;
  localparam logic [2:0] SPR_DOWN_1P0 = 3'h1;
  localparam logic [2:0] SPR_DOWN_2P0 = 3'h2;
  localparam logic [2:0] SPR_DOWN_2P5 = 3'h3;
  localparam logic [2:0] SPR_CTR_0P25 = 3'h4;
  localparam logic [2:0] SPR_CTR_0P5 = 3'h5;
  localparam logic [2:0] SPR_CTR_1P0 = 3'h6;
  localparam logic [2:0] SPR_CTR_1P25 = 3'h7;

  // ==========================================================
  // Byte phases of a transfer
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_INDEX = 2'b01,
    PH_COUNT = 2'b10,
    PH_DATA = 2'b11
  } phase_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_TX_ACK = 3'b100
  } slave_state_e;

endpackage

// >>> rtl/smbus_evt_if.sv
// Carrier for line events from the line watcher to the slave core.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
interface smbus_evt_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;
  modport watcher (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport core (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

// >>> rtl/smbus_line_watch.sv
// Edge and condition detector for the two serial lines.
// Assumes i_scl and i_sda are already synchronous to i_clk_sys.
`timescale 1ns/1ps
module smbus_line_watch (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  smbus_evt_if.watcher evt
);

  // ==========================================================
  // Previous line levels
  logic scl_reg;
  logic sda_reg;

  // Idle bus is high on both lines, so reset to high avoids a false stop or clock rise
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= i_scl;
      sda_reg <= i_sda;
    end
  end

  // ==========================================================
  // Event pulses, one cycle each, plus the registered data line level
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      evt.scl_rise <= 1'b0;
      evt.scl_fall <= 1'b0;
      evt.start <= 1'b0;
      evt.stop <= 1'b0;
      evt.sda <= 1'b1;
    end else begin
      evt.scl_rise <= i_scl & ~scl_reg;
      evt.scl_fall <= ~i_scl & scl_reg;
      evt.start <= i_scl & scl_reg & sda_reg & ~i_sda;
      evt.stop <= i_scl & scl_reg & ~sda_reg & i_sda;
      evt.sda <= i_sda;
    end
  end

endmodule

// >>> rtl/clkgen_ctl_bank.sv
// Control byte bank of a multi-output clock generator with its serial slave.
// Assumes lines are synchronous to i_clk_sys and the host paces the serial clock.
`timescale 1ns/1ps
// Operation
// RULE1: Host opens a read with start and write address byte.
// RULE2: Host then sends the index of the first byte to read.
// RULE3: Device acknowledges the address byte and the index byte.
// RULE4: Host sends repeated start then the read address byte.
// RULE5: Device acknowledges read address, then drives data for the rest.
// RULE6: First returned byte is the byte count.
// RULE7: Then bytes from index N through N plus count minus one.
// RULE8: Host acknowledges count and every data byte but the last.
// RULE9: Host ends read with not-acknowledge then stop.
// RULE10: Byte 0 bit 7 switches the main synthesizer; resets to 1.
// RULE11: Byte 0 bit 6 switches the dot synthesizer; resets to 1.
// RULE12: Byte 0 bit 5 switches display synthesizer; bit 4 reserved zero.
// RULE13: Byte 0 bits 3..0 enable proc, serref, display, dot dividers.
// RULE14: Clearing a synthesizer bit clears the dividers it feeds.
// RULE15: Byte 1 bit 7 enables fixed down-spread on main synthesizer.
// RULE16: Byte 1 bit 6 enables spread on display synthesizer.
// RULE17: Byte 1 bits 5..3 select display spread; bits 2..0 reserved.
// RULE18: Select codes 0..3 down-spread, 4..7 center-spread amounts.
// RULE19: Byte 2 bits 7..5 enable processor output buffers a..c.
// RULE20: Byte 2 bits 4..2 enable serial-reference output buffers a..c.
// RULE21: Byte 2 bit 1 enables the dot output buffer.
// RULE22: Byte 2 bit 0 enables the display output buffer.
// RULE23: Block write is address, index, count, data bytes, stop.
// RULE24: Disabled output without power-down parks true low/20K, complement low.
// RULE25: Index advances by one after each data byte transferred.
// RULE26: Reserved bits ignore writes and read as reset value.
module clkgen_ctl_bank (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_power_down,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_main_synth_on,
  output logic o_dot_synth_on,
  output logic o_display_synth_on,
  output logic o_proc_div_on,
  output logic o_serref_div_on,
  output logic o_display_div_on,
  output logic o_dotclk_div_on,
  output logic o_main_synth_spread_on,
  output logic o_display_synth_spread_on,
  output logic [2:0] o_display_spread_sel,
  output logic o_display_spread_center,
  output logic [7:0] o_out_running
);

  // ==========================================================
  // Line events
  smbus_evt_if evt ();

  smbus_line_watch u_watch (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .evt(evt)
  );

  // ==========================================================
  // State
  clkgen_ctl_pkg::slave_state_e state_reg;
  clkgen_ctl_pkg::phase_e phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] index_reg;
  logic [7:0] count_reg;
  logic read_mode_reg;
  logic ack_ok_reg;
  logic [7:0] byte0_reg;
  logic [7:0] byte1_reg;
  logic [7:0] byte2_reg;
  logic [7:0] rd_byte;
  logic [7:0] b0_wr;

  // Unmapped indices read zero so a long read never stalls the host
  always_comb begin
    case (index_reg)
      clkgen_ctl_pkg::IDX_SYNTH_DIV: rd_byte = byte0_reg;
      clkgen_ctl_pkg::IDX_SPREAD: rd_byte = byte1_reg;
      clkgen_ctl_pkg::IDX_OUT_EN: rd_byte = byte2_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  // Divider bits follow their synthesizer down in the same write
  always_comb begin
    b0_wr = shift_reg & clkgen_ctl_pkg::B0_WRITABLE; // [RULE26]
    if (!shift_reg[clkgen_ctl_pkg::B0_MAIN_SYNTH]) begin
      b0_wr[clkgen_ctl_pkg::B0_PROC_DIV] = 1'b0; // [RULE14]
      b0_wr[clkgen_ctl_pkg::B0_SERREF_DIV] = 1'b0; // [RULE14]
    end
    if (!shift_reg[clkgen_ctl_pkg::B0_DISP_SYNTH]) begin
      b0_wr[clkgen_ctl_pkg::B0_DISP_DIV] = 1'b0; // [RULE14]
    end
    if (!shift_reg[clkgen_ctl_pkg::B0_DOT_SYNTH]) begin
      b0_wr[clkgen_ctl_pkg::B0_DOT_DIV] = 1'b0; // [RULE14]
    end
  end

  // ==========================================================
  // Byte-level slave sequencer
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= clkgen_ctl_pkg::ST_IDLE;
      phase_reg <= clkgen_ctl_pkg::PH_ADDR;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      read_mode_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (evt.stop) begin
      state_reg <= clkgen_ctl_pkg::ST_IDLE;
      o_sda_oe <= 1'b0;
    end else if (evt.start) begin
      // A repeated start restarts address capture in any state
      state_reg <= clkgen_ctl_pkg::ST_RX;
      phase_reg <= clkgen_ctl_pkg::PH_ADDR;
      bit_cnt_reg <= 4'h0;
      o_sda_oe <= 1'b0;
    end else begin
      case (state_reg)
        clkgen_ctl_pkg::ST_IDLE: begin
          o_sda_oe <= 1'b0;
        end
        clkgen_ctl_pkg::ST_RX: begin
          if (evt.scl_rise && bit_cnt_reg != 4'h8) begin
            shift_reg <= {shift_reg[6:0], evt.sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (evt.scl_fall && bit_cnt_reg == 4'h8) begin
            state_reg <= clkgen_ctl_pkg::ST_RX_ACK;
            ack_ok_reg <= 1'b1;
            o_sda_oe <= 1'b1; // [RULE3]
            case (phase_reg)
              clkgen_ctl_pkg::PH_ADDR: begin
                if (shift_reg == clkgen_ctl_pkg::WR_ADDR_BYTE) begin
                  read_mode_reg <= 1'b0;
                  phase_reg <= clkgen_ctl_pkg::PH_INDEX;
                end else if (shift_reg == clkgen_ctl_pkg::RD_ADDR_BYTE) begin
                  read_mode_reg <= 1'b1; // [RULE5]
                end else begin
                  ack_ok_reg <= 1'b0;
                  o_sda_oe <= 1'b0;
                end
              end
              clkgen_ctl_pkg::PH_INDEX: begin
                phase_reg <= clkgen_ctl_pkg::PH_COUNT; // [RULE23]
              end
              clkgen_ctl_pkg::PH_COUNT: begin
                phase_reg <= clkgen_ctl_pkg::PH_DATA;
              end
              default: begin
                phase_reg <= clkgen_ctl_pkg::PH_DATA;
              end
            endcase
          end
        end
        clkgen_ctl_pkg::ST_RX_ACK: begin
          if (evt.scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (!ack_ok_reg) begin
              state_reg <= clkgen_ctl_pkg::ST_IDLE;
              o_sda_oe <= 1'b0;
            end else if (read_mode_reg) begin
              // Count byte goes out first, high bit on this same fall
              state_reg <= clkgen_ctl_pkg::ST_TX;
              shift_reg <= {count_reg[6:0], 1'b0}; // [RULE6]
              o_sda_oe <= ~count_reg[7]; // [RULE5]
              bit_cnt_reg <= 4'h1;
            end else begin
              state_reg <= clkgen_ctl_pkg::ST_RX;
              o_sda_oe <= 1'b0;
            end
          end
        end
        clkgen_ctl_pkg::ST_TX: begin
          if (evt.scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              state_reg <= clkgen_ctl_pkg::ST_TX_ACK;
              o_sda_oe <= 1'b0;
            end else begin
              o_sda_oe <= ~shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        clkgen_ctl_pkg::ST_TX_ACK: begin
          if (evt.scl_rise) begin
            ack_ok_reg <= ~evt.sda; // [RULE8]
          end else if (evt.scl_fall) begin
            if (ack_ok_reg) begin
              state_reg <= clkgen_ctl_pkg::ST_TX;
              shift_reg <= {rd_byte[6:0], 1'b0}; // [RULE7]
              o_sda_oe <= ~rd_byte[7];
              bit_cnt_reg <= 4'h1;
            end else begin
              // Not-acknowledge ends the read; wait for stop
              state_reg <= clkgen_ctl_pkg::ST_IDLE; // [RULE9]
            end
          end
        end
        default: begin
          state_reg <= clkgen_ctl_pkg::ST_IDLE;
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Register index and stored byte count
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      index_reg <= 8'h00;
      count_reg <= clkgen_ctl_pkg::NUM_BYTES;
    end else if (!evt.stop && !evt.start && evt.scl_fall) begin
      if (state_reg == clkgen_ctl_pkg::ST_RX && bit_cnt_reg == 4'h8) begin
        if (phase_reg == clkgen_ctl_pkg::PH_INDEX) begin
          index_reg <= shift_reg; // [RULE2]
        end else if (phase_reg == clkgen_ctl_pkg::PH_COUNT) begin
          count_reg <= shift_reg;
        end else if (phase_reg == clkgen_ctl_pkg::PH_DATA && !read_mode_reg) begin
          index_reg <= index_reg + 8'h01; // [RULE25]
        end
      end else if (state_reg == clkgen_ctl_pkg::ST_TX_ACK && ack_ok_reg) begin
        index_reg <= index_reg + 8'h01; // [RULE25]
      end
    end
  end

  // ==========================================================
  // Control bytes
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      byte0_reg <= clkgen_ctl_pkg::B0_RESET; // [RULE10] [RULE11] [RULE12] [RULE13]
      byte1_reg <= clkgen_ctl_pkg::B1_RESET; // [RULE15] [RULE16] [RULE17]
      byte2_reg <= clkgen_ctl_pkg::B2_RESET; // [RULE19] [RULE20] [RULE21] [RULE22]
    end else if (!evt.stop && !evt.start && evt.scl_fall
                 && state_reg == clkgen_ctl_pkg::ST_RX && bit_cnt_reg == 4'h8
                 && phase_reg == clkgen_ctl_pkg::PH_DATA && !read_mode_reg) begin
      case (index_reg)
        clkgen_ctl_pkg::IDX_SYNTH_DIV: byte0_reg <= b0_wr;
        clkgen_ctl_pkg::IDX_SPREAD: begin
          byte1_reg <= shift_reg & clkgen_ctl_pkg::B1_WRITABLE; // [RULE26]
        end
        clkgen_ctl_pkg::IDX_OUT_EN: byte2_reg <= shift_reg & clkgen_ctl_pkg::B2_WRITABLE;
        default: byte2_reg <= byte2_reg;
      endcase
    end
  end

  // ==========================================================
  // Registered controls toward the synthesizers and buffers
  logic [7:0] family_div;
  logic [2:0] sel_now;

  // Each output buffer also needs its divider running
  always_comb begin
    family_div = {{3{byte0_reg[clkgen_ctl_pkg::B0_PROC_DIV]}},
                  {3{byte0_reg[clkgen_ctl_pkg::B0_SERREF_DIV]}},
                  byte0_reg[clkgen_ctl_pkg::B0_DOT_DIV],
                  byte0_reg[clkgen_ctl_pkg::B0_DISP_DIV]};
    sel_now = byte1_reg[clkgen_ctl_pkg::B1_SEL_LSB +: 3];
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sda_out <= 1'b0;
      o_main_synth_on <= 1'b1;
      o_dot_synth_on <= 1'b1;
      o_display_synth_on <= 1'b1;
      o_proc_div_on <= 1'b1;
      o_serref_div_on <= 1'b1;
      o_display_div_on <= 1'b1;
      o_dotclk_div_on <= 1'b1;
      o_main_synth_spread_on <= 1'b1;
      o_display_synth_spread_on <= 1'b1;
      o_display_spread_sel <= clkgen_ctl_pkg::SPR_DOWN_0P5;
      o_display_spread_center <= 1'b0;
      o_out_running <= 8'h00;
    end else begin
      // Open drain: data line is only ever pulled low
      o_sda_out <= 1'b0;
      o_main_synth_on <= byte0_reg[clkgen_ctl_pkg::B0_MAIN_SYNTH]; // [RULE10]
      o_dot_synth_on <= byte0_reg[clkgen_ctl_pkg::B0_DOT_SYNTH]; // [RULE11]
      o_display_synth_on <= byte0_reg[clkgen_ctl_pkg::B0_DISP_SYNTH]; // [RULE12]
      o_proc_div_on <= byte0_reg[clkgen_ctl_pkg::B0_PROC_DIV]; // [RULE13]
      o_serref_div_on <= byte0_reg[clkgen_ctl_pkg::B0_SERREF_DIV]; // [RULE13]
      o_display_div_on <= byte0_reg[clkgen_ctl_pkg::B0_DISP_DIV]; // [RULE13]
      o_dotclk_div_on <= byte0_reg[clkgen_ctl_pkg::B0_DOT_DIV]; // [RULE13]
      o_main_synth_spread_on <= byte1_reg[clkgen_ctl_pkg::B1_MAIN_SPREAD]; // [RULE15]
      o_display_synth_spread_on <= byte1_reg[clkgen_ctl_pkg::B1_DISP_SPREAD]; // [RULE16]
      o_display_spread_sel <= sel_now; // [RULE17]
      o_display_spread_center <= (sel_now >= clkgen_ctl_pkg::SPR_CTR_0P25); // [RULE18]
      // Stopped pair: true side low/20K, complement low
      o_out_running <= byte2_reg & family_div & {8{~i_power_down}}; // [RULE24]
    end
  end

endmodule

// >>> verification/clkgen_ctl_bank_asserts.sv
// Assertion checker for the control byte bank, attached by bind.
// Assumes one clock domain and sight of the bank's top-level ports only.
`timescale 1ns/1ps
module clkgen_ctl_bank_checker (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_power_down,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_main_synth_on,
  input wire logic o_dot_synth_on,
  input wire logic o_display_synth_on,
  input wire logic o_proc_div_on,
  input wire logic o_serref_div_on,
  input wire logic o_display_div_on,
  input wire logic o_dotclk_div_on,
  input wire logic [2:0] o_display_spread_sel,
  input wire logic o_display_spread_center,
  input wire logic [7:0] o_out_running
);
  // ====================================
  // Divider and output checks
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  a_main_div_clear: assert property (!o_main_synth_on |->
    !o_proc_div_on && !o_serref_div_on) else $error("main divider on with synth off");
  a_disp_div_clear: assert property (!o_display_synth_on |-> !o_display_div_on)
    else $error("display divider on with synth off");
  a_dot_div_clear: assert property (!o_dot_synth_on |-> !o_dotclk_div_on)
    else $error("dot divider on with synth off");
  // Two cycles of divider off allow for either output lag
  a_proc_out_off: assert property (!o_proc_div_on && $past(!o_proc_div_on) |->
    o_out_running[7:5] == 3'h0) else $error("proc output runs without divider");
  a_serref_out_off: assert property (!o_serref_div_on && $past(!o_serref_div_on) |->
    o_out_running[4:2] == 3'h0) else $error("serref output runs without divider");
  a_dot_out_off: assert property (!o_dotclk_div_on && $past(!o_dotclk_div_on) |->
    !o_out_running[1]) else $error("dot output runs without divider");
  a_pd_gates_out: assert property (i_power_down |=> o_out_running == 8'h00)
    else $error("output runs in power-down");
  a_center_decode: assert property (o_display_spread_center == o_display_spread_sel[2])
    else $error("center flag disagrees with select");
  // ====================================
  // Serial line checks
  a_sda_open_drain: assert property (o_sda_out == 1'b0)
    else $error("data line driven high");
  a_drive_on_low: assert property ($rose(o_sda_oe) |-> !$past(i_scl) && !i_scl)
    else $error("data drive began with clock high");
  a_stop_release: assert property (i_scl && $rose(i_sda) |-> ##4 !o_sda_oe)
    else $error("data line held after stop");
  a_cfg_on_low: assert property ($changed({o_main_synth_on, o_dot_synth_on,
    o_proc_div_on, o_display_spread_sel}) |-> !$past(i_scl))
    else $error("config changed off a byte end");
endmodule
bind clkgen_ctl_bank clkgen_ctl_bank_checker clkgen_ctl_bank_checker_i (
  .i_clk_sys(i_clk_sys),
  .i_resetn(i_resetn),
  .i_scl(i_scl),
  .i_sda(i_sda),
  .i_power_down(i_power_down),
  .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe),
  .o_main_synth_on(o_main_synth_on),
  .o_dot_synth_on(o_dot_synth_on),
  .o_display_synth_on(o_display_synth_on),
  .o_proc_div_on(o_proc_div_on),
  .o_serref_div_on(o_serref_div_on),
  .o_display_div_on(o_display_div_on),
  .o_dotclk_div_on(o_dotclk_div_on),
  .o_display_spread_sel(o_display_spread_sel),
  .o_display_spread_center(o_display_spread_center),
  .o_out_running(o_out_running)
);

// >>> verification/smbus_host_model.sv
// Serial host model: start, stop and byte transfers on a pulled-up line.
// Assumes the bench resolves the line from both parties' pull-downs.
`timescale 1ns/1ps
module smbus_host_model (
  input wire logic i_clk_sys,
  input wire logic i_sda_line,
  output logic o_scl,
  output logic o_sda_low
);
  // ====================================
  // Line timing: six cycles a half bit, above the bank's minimum of four
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic half();
    repeat (6) @(posedge i_clk_sys);
  endtask
  // Start and repeated start alike: data falls while clock is high
  task automatic start();
    @(posedge i_clk_sys);
    o_sda_low <= 1'b0;
    half();
    o_scl <= 1'b1;
    half();
    o_sda_low <= 1'b1;
    half();
    o_scl <= 1'b0;
    half();
  endtask
  task automatic stop();
    o_sda_low <= 1'b1;
    half();
    o_scl <= 1'b1;
    half();
    o_sda_low <= 1'b0;
    half();
  endtask
  // Data changes only with clock low; released data reads the pull-up
  task automatic bit_io(input logic b, output logic r);
    o_sda_low <= ~b;
    half();
    o_scl <= 1'b1;
    half();
    r = i_sda_line;
    o_scl <= 1'b0;
    half();
  endtask
  // Send 1s to release the line; ack_in low acks, high ends a read
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
    output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_out);
  endtask
endmodule

// >>> verification/clkgen_ctl_bank_tb.sv
// Testbench: block writes and reads of the control bytes via the host model.
// Assumes the bank and smbus_host_model; line has a pull-up.
`timescale 1ns/1ps
module clkgen_ctl_bank_tb;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic i_power_down = 1'b0;
  logic o_sda_out, o_sda_oe, o_main_synth_on, o_dot_synth_on, o_display_synth_on;
  logic o_proc_div_on, o_serref_div_on, o_display_div_on, o_dotclk_div_on;
  logic o_main_synth_spread_on, o_display_synth_spread_on, o_display_spread_center;
  logic [2:0] o_display_spread_sel;
  logic [7:0] o_out_running;
  logic scl, sda_low, ack;
  logic [7:0] rx;
  logic [2:0] sel;
  int errors = 0;
  int n_tests = 0;
  wire sda_line = ~(sda_low | o_sda_oe);
  wire [7:0] b0_out = {o_main_synth_on, o_dot_synth_on, o_display_synth_on, 1'b0,
    o_proc_div_on, o_serref_div_on, o_display_div_on, o_dotclk_div_on};
  wire [7:0] b1_out = {o_main_synth_spread_on, o_display_synth_spread_on,
    o_display_spread_sel, 3'h0};
  logic [7:0] w0 [5] = '{8'h7F, 8'hDF, 8'hBF, 8'h10, 8'hFF};
  logic [7:0] e0 [5] = '{8'h63, 8'hCD, 8'hAE, 8'h00, 8'hEF};
  logic [7:0] r0 [5] = '{8'h03, 8'hFE, 8'hFD, 8'h00, 8'hFF};
  always #2.5 i_clk_sys = ~i_clk_sys;
  clkgen_ctl_bank clkgen_ctl_bank_i (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_scl(scl), .i_sda(sda_line), .i_power_down(i_power_down),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_main_synth_on(o_main_synth_on),
    .o_dot_synth_on(o_dot_synth_on), .o_display_synth_on(o_display_synth_on),
    .o_proc_div_on(o_proc_div_on), .o_serref_div_on(o_serref_div_on),
    .o_display_div_on(o_display_div_on), .o_dotclk_div_on(o_dotclk_div_on),
    .o_main_synth_spread_on(o_main_synth_spread_on),
    .o_display_synth_spread_on(o_display_synth_spread_on),
    .o_display_spread_sel(o_display_spread_sel),
    .o_display_spread_center(o_display_spread_center), .o_out_running(o_out_running));
  smbus_host_model smbus_host_model_i (.i_clk_sys(i_clk_sys), .i_sda_line(sda_line),
    .o_scl(scl), .o_sda_low(sda_low));
  // ====================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic put(input logic [7:0] b);
    smbus_host_model_i.xfer(b, 1'b1, rx, ack);
    check({7'h0, ack}, 8'h00);
  endtask
  task automatic wr(input logic [7:0] idx, input int n, input logic [7:0] d [3]);
    smbus_host_model_i.start();
    put(clkgen_ctl_pkg::WR_ADDR_BYTE);
    put(idx);
    put(n[7:0]);
    for (int i = 0; i < n; i++) put(d[i]);
    smbus_host_model_i.stop();
    repeat (4) @(negedge i_clk_sys);
  endtask
  task automatic rd(input logic [7:0] idx, input int n, input logic [7:0] e [3]);
    smbus_host_model_i.start();
    put(clkgen_ctl_pkg::WR_ADDR_BYTE);
    put(idx);
    smbus_host_model_i.start();
    smbus_host_model_i.xfer(clkgen_ctl_pkg::RD_ADDR_BYTE, 1'b1, rx, ack);
    check({7'h0, ack}, 8'h00);
    smbus_host_model_i.xfer(8'hFF, 1'b0, rx, ack);
    check(rx, n[7:0]);
    for (int i = 0; i < n; i++) begin
      smbus_host_model_i.xfer(8'hFF, i == n - 1, rx, ack);
      check(rx, e[i]);
    end
    smbus_host_model_i.stop();
    repeat (4) @(negedge i_clk_sys);
  endtask
  // ====================================
  // Tests
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    repeat (2) @(negedge i_clk_sys);
    check(b0_out, 8'hEF);
    check(b1_out, 8'hC0);
    check(o_out_running, 8'hFF);
    rd(8'h00, 3, '{8'hEF, 8'hC0, 8'hFF});
    $display("test reset values done");
    for (int k = 0; k < 5; k++) begin
      wr(8'h00, 1, '{w0[k], 8'h00, 8'h00});
      check(b0_out, e0[k]);
      check(o_out_running, r0[k]);
      rd(8'h00, 1, '{e0[k], 8'h00, 8'h00});
    end
    $display("test synth and divider enables done");
    for (int s = 0; s < 8; s++) begin
      sel = s[2:0];
      // Main spread follows sel[1] so the enable is seen both cleared and set
      wr(8'h01, 2, '{{sel[1], sel[0], sel, 3'h7}, ~(8'h01 << s), 8'h00});
      check(b1_out, {sel[1], sel[0], sel, 3'h0});
      check({7'h0, o_display_spread_center}, {7'h0, sel[2]});
      check(o_out_running, ~(8'h01 << s));
    end
    rd(8'h01, 2, '{8'hF8, 8'h7F, 8'h00});
    $display("test spread and buffer enables done");
    @(posedge i_clk_sys) i_power_down <= 1'b1;
    repeat (3) @(negedge i_clk_sys);
    check(o_out_running, 8'h00);
    @(posedge i_clk_sys) i_power_down <= 1'b0;
    repeat (3) @(negedge i_clk_sys);
    check(o_out_running, 8'h7F);
    $display("test power-down done");
    smbus_host_model_i.start();
    smbus_host_model_i.xfer(8'hA4, 1'b1, rx, ack);
    check({7'h0, ack}, 8'h01);
    smbus_host_model_i.stop();
    wr(8'h03, 1, '{8'h00, 8'h00, 8'h00});
    rd(8'h00, 1, '{8'hEF, 8'h00, 8'h00});
    $display("test refused accesses done");
    test_done();
  end
  // Tests take about 20000 cycles; the limit leaves ample margin
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    errors++;
    test_done();
  end
endmodule
